// >>> verilog/wdrw_pkg.sv
// shared constants and carrier types for the watchdog block
package wdrw_pkg;
  // nominal expiry period without prescale, in microseconds
  localparam int unsigned WDRW_PERIOD_US = 18000;
  // clock rate of the counting oscillator, in MHz
  localparam int unsigned WDRW_CLK_MHZ = 100;
  // nominal period, exactly: whole cycles of the oscillator
  localparam int unsigned WDRW_PERIOD_CYCLES = WDRW_PERIOD_US * WDRW_CLK_MHZ;
  // width of the base period counter
  localparam int unsigned WDRW_BASE_W = 21;
  // width of the shared prescaler count (largest ratio 1:128)
  localparam int unsigned WDRW_PRE_W = 7;
  // width of the prescale ratio field
  localparam int unsigned WDRW_RATIO_W = 3;
  // reset value of the expiry flag: set, no time-out seen
  localparam logic WDRW_FLAG_RST = 1'h1;

  // prescaler configuration as the option register holds it
  typedef struct packed {
    logic to_watchdog; // 1: prescaler serves the watchdog
    logic [WDRW_RATIO_W-1:0] ratio; // power-of-two exponent 0..7
  } wdrw_presc_cfg_t;

  // whole state of the watchdog
  typedef struct packed {
    logic [WDRW_BASE_W-1:0] base_cnt;
    logic [WDRW_PRE_W-1:0] pre_cnt;
    logic expiry_flag;
    logic reset_pulse;
    logic wake_pulse;
  } wdrw_state_t;
endpackage : wdrw_pkg

// >>> verilog/wdrw_watchdog.sv
// watchdog timer with reset in run mode and wake-up in sleep mode
`timescale 1ns/1ps
module wdrw_watchdog #(
  parameter int unsigned BASE_CYCLES = wdrw_pkg::WDRW_PERIOD_CYCLES
) (
  // clock and reset; mclk stands for the watchdog's own oscillator
  input wire logic mclk,
  input wire logic reset,
  // configuration fuse, static after power-up
  input wire logic watchdog_enable_fuse,
  // prescaler assignment and ratio from the option register
  input wire wdrw_pkg::wdrw_presc_cfg_t presc_cfg,
  // core state and instruction strobes, one cycle each
  input wire logic core_in_sleep,
  input wire logic clear_watchdog_instr,
  input wire logic sleep_instr,
  // results towards the core
  output logic watchdog_reset,
  output logic watchdog_wake,
  output logic expiry_flag
);

  // refuse periods the base counter cannot hold; checked while elaborating
  if (BASE_CYCLES < 2 || BASE_CYCLES >= (1 << wdrw_pkg::WDRW_BASE_W)) begin : g_bad_period
    $error("BASE_CYCLES out of range");
  end
  // the prescaler count must reach the last value of the largest ratio
  if (wdrw_pkg::WDRW_PRE_W < (1 << wdrw_pkg::WDRW_RATIO_W) - 1) begin : g_bad_presc
    $error("prescaler count too narrow");
  end

  // terminal value of the base counter at the counter's width
  localparam logic [wdrw_pkg::WDRW_BASE_W-1:0] BASE_LAST =
    wdrw_pkg::WDRW_BASE_W'(BASE_CYCLES - 1);

  wdrw_pkg::wdrw_state_t st_reg; // registered state
  wdrw_pkg::wdrw_state_t st_next; // next state
  logic restart; // clear or sleep instruction this cycle
  logic tick; // one prescaled step of the base counter
  logic expire; // base period elapsed this cycle
  logic [wdrw_pkg::WDRW_PRE_W-1:0] pre_mask; // last prescaler count

  // next-state logic
  always_comb begin
    st_next = st_reg;
    restart = clear_watchdog_instr | sleep_instr;
    // ratio 2**n means the prescaler wraps at 2**n - 1
    pre_mask = wdrw_pkg::WDRW_PRE_W'((8'h01 << presc_cfg.ratio) - 8'h01);
    // unassigned prescaler leaves the watchdog at 1:1; a count left above
    // the mask by a smaller ratio ticks at once instead of waiting for a wrap
    tick = ~presc_cfg.to_watchdog | (st_reg.pre_cnt >= pre_mask);
    expire = watchdog_enable_fuse & ~restart & tick & (st_reg.base_cnt == BASE_LAST);
    st_next.reset_pulse = 1'h0;
    st_next.wake_pulse = 1'h0;
    if (!watchdog_enable_fuse) begin
      // a blown fuse holds everything still; no input can restart it
      st_next.base_cnt = '0;
      st_next.pre_cnt = '0;
    end else if (restart) begin
      // counts cleared, assignment bits untouched (they are inputs)
      st_next.base_cnt = '0;
      st_next.pre_cnt = '0;
    end else begin
      // runs regardless of core sleep: this clock never stops
      if (presc_cfg.to_watchdog) begin
        st_next.pre_cnt = tick ? '0 : st_reg.pre_cnt + 1'h1;
      end else begin
        st_next.pre_cnt = '0;
      end
      if (expire) begin
        st_next.base_cnt = '0;
      end else if (tick) begin
        st_next.base_cnt = st_reg.base_cnt + 1'h1;
      end
    end
    if (expire) begin
      // sleep turns the time-out into a wake-up
      st_next.reset_pulse = ~core_in_sleep;
      st_next.wake_pulse = core_in_sleep;
      // hardware clear wins; flag is set again only by power-up reset
      st_next.expiry_flag = 1'h0;
    end
  end

  // state register
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_reg <= '{base_cnt: '0, pre_cnt: '0, expiry_flag: wdrw_pkg::WDRW_FLAG_RST,
                  reset_pulse: 1'h0, wake_pulse: 1'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign watchdog_reset = st_reg.reset_pulse;
  assign watchdog_wake = st_reg.wake_pulse;
  assign expiry_flag = st_reg.expiry_flag;

  // an expiry in run or sleep mode, seen at the outputs one cycle later
  sequence s_expire_run;
    expire && !core_in_sleep;
  endsequence
  sequence s_expire_sleep;
    expire && core_in_sleep;
  endsequence

  property p_counts_in_sleep;
    @(posedge mclk) disable iff (reset)
      core_in_sleep && watchdog_enable_fuse && !restart && tick && !expire
      |=> st_reg.base_cnt == $past(st_reg.base_cnt) + 1'h1;
  endproperty
  a_counts_in_sleep: assert property (p_counts_in_sleep) else $error("no count in sleep");

  property p_run_reset;
    @(posedge mclk) disable iff (reset)
      s_expire_run |=> watchdog_reset && !watchdog_wake;
  endproperty
  a_run_reset: assert property (p_run_reset) else $error("run expiry gave no reset");

  property p_sleep_wake;
    @(posedge mclk) disable iff (reset)
      s_expire_sleep |=> watchdog_wake && !watchdog_reset;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep expiry gave no wake");

  property p_fuse_off;
    @(posedge mclk) disable iff (reset)
      !watchdog_enable_fuse ##1 !watchdog_enable_fuse |-> !watchdog_reset && !watchdog_wake;
  endproperty
  a_fuse_off: assert property (p_fuse_off) else $error("disabled watchdog fired");

  // a pulse may only follow a tick taken at the last base count
  property p_period;
    @(posedge mclk) disable iff (reset)
      (watchdog_reset || watchdog_wake) |-> $past(st_reg.base_cnt) == BASE_LAST && $past(tick);
  endproperty
  a_period: assert property (p_period) else $error("expiry before full period");

  property p_presc_bound;
    @(posedge mclk) disable iff (reset)
      presc_cfg.to_watchdog && $stable(presc_cfg) |-> st_reg.pre_cnt <= pre_mask;
  endproperty
  a_presc_bound: assert property (p_presc_bound) else $error("prescaler passed ratio");

  property p_restart;
    @(posedge mclk) disable iff (reset)
      restart && watchdog_enable_fuse |=> st_reg.base_cnt == '0 && st_reg.pre_cnt == '0
        && !watchdog_reset && !watchdog_wake;
  endproperty
  a_restart: assert property (p_restart) else $error("restart did not clear counts");

  property p_flag_clear;
    @(posedge mclk) disable iff (reset)
      (watchdog_reset || watchdog_wake) |-> !expiry_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag still set after expiry");

  property p_unassigned;
    @(posedge mclk) disable iff (reset)
      !presc_cfg.to_watchdog |=> st_reg.pre_cnt == '0;
  endproperty
  a_unassigned: assert property (p_unassigned) else $error("unassigned prescaler ran");

  // a tick short of the last base count must not give any pulse
  property p_no_early;
    @(posedge mclk) disable iff (reset)
      watchdog_enable_fuse && tick && st_reg.base_cnt != BASE_LAST |=> !watchdog_reset && !watchdog_wake;
  endproperty
  a_no_early: assert property (p_no_early) else $error("early expiry");

  // between prescaler ticks the base count must hold
  property p_base_hold;
    @(posedge mclk) disable iff (reset)
      watchdog_enable_fuse && !restart && !tick |=> st_reg.base_cnt == $past(st_reg.base_cnt);
  endproperty
  a_base_hold: assert property (p_base_hold) else $error("base moved without tick");

  // an assigned prescaler steps by one until it reaches the ratio's last value
  property p_pre_step;
    @(posedge mclk) disable iff (reset)
      presc_cfg.to_watchdog && watchdog_enable_fuse && !restart && !tick
      |=> st_reg.pre_cnt == $past(st_reg.pre_cnt) + 1'h1;
  endproperty
  a_pre_step: assert property (p_pre_step) else $error("prescaler misstep");

  // a clear while the prescaler serves the watchdog
  sequence s_clear_assigned;
    clear_watchdog_instr && presc_cfg.to_watchdog && watchdog_enable_fuse;
  endsequence

  // after that clear the base must still wait for the prescaler, not run at 1:1
  property p_assign_kept;
    @(posedge mclk) disable iff (reset)
      s_clear_assigned ##1 $stable(presc_cfg) |-> tick == (pre_mask == '0);
  endproperty
  a_assign_kept: assert property (p_assign_kept) else $error("assignment lost");

  // a blown fuse keeps both counts at zero
  property p_fuse_hold;
    @(posedge mclk) disable iff (reset)
      !watchdog_enable_fuse |=> st_reg.base_cnt == '0 && st_reg.pre_cnt == '0;
  endproperty
  a_fuse_hold: assert property (p_fuse_hold) else $error("disabled watchdog counted");

  // a pulse lasts one cycle: the base restarts from zero after expiry
  property p_single_pulse;
    @(posedge mclk) disable iff (reset)
      (watchdog_reset || watchdog_wake) |=> !watchdog_reset && !watchdog_wake;
  endproperty
  a_single_pulse: assert property (p_single_pulse) else $error("pulse too long");

  // one expiry is either a reset or a wake-up, never both
  property p_one_cause;
    @(posedge mclk) disable iff (reset)
      !(watchdog_reset && watchdog_wake);
  endproperty
  a_one_cause: assert property (p_one_cause) else $error("reset and wake together");

  // only the reset input sets the flag again
  property p_flag_sticky;
    @(posedge mclk) disable iff (reset)
      !expiry_flag |=> !expiry_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag set without reset");

endmodule : wdrw_watchdog

// >>> dv/wdrw_core_model.sv
// core model that issues clear and sleep instructions to the watchdog
`timescale 1ns/1ps
module wdrw_core_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // results from the watchdog
  input wire logic watchdog_reset,
  input wire logic watchdog_wake,
  // instruction strobes and sleep state
  output logic clear_watchdog_instr,
  output logic sleep_instr,
  output logic core_in_sleep
);
  initial begin
    clear_watchdog_instr = 1'b0;
    sleep_instr = 1'b0;
    core_in_sleep = 1'b0;
  end
  // a parked core resumes on wake-up or on any device reset
  always @(negedge mclk) begin
    if (watchdog_wake || watchdog_reset || reset) begin
      core_in_sleep = 1'b0;
    end
  end
  // one-cycle strobe; sleep also parks the core until woken
  task automatic exec(input logic slp);
    clear_watchdog_instr = !slp;
    sleep_instr = slp;
    core_in_sleep = slp;
    @(negedge mclk);
    clear_watchdog_instr = 1'b0;
    sleep_instr = 1'b0;
  endtask : exec
endmodule : wdrw_core_model

// >>> dv/tb_top.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ps
module tb_top;
  // one row: prescaler setting, sleep choice, cycles to expiry
  typedef struct packed {
    wdrw_pkg::wdrw_presc_cfg_t cfg;
    logic slp;
    logic [9:0] n;
  } wdrw_row_t;
  localparam int NB = 4; // short base period keeps the run brief
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic fuse = 1'b1;
  wdrw_pkg::wdrw_presc_cfg_t cfg = 4'h0;
  logic clr, slp_i, in_sleep, wd_rst, wd_wake, flag;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  wdrw_row_t rows [10] = '{'{4'h0, 1'b0, 10'h004}, '{4'h8, 1'b1, 10'h004},
    '{4'h9, 1'b0, 10'h008}, '{4'hA, 1'b1, 10'h010}, '{4'hB, 1'b0, 10'h020},
    '{4'hC, 1'b1, 10'h040}, '{4'hD, 1'b0, 10'h080}, '{4'hE, 1'b1, 10'h100},
    '{4'hF, 1'b0, 10'h200}, '{4'h7, 1'b1, 10'h004}};
  always #5 mclk = ~mclk;
  wdrw_watchdog #(.BASE_CYCLES(NB)) DUT (.mclk(mclk), .reset(reset),
    .watchdog_enable_fuse(fuse), .presc_cfg(cfg), .core_in_sleep(in_sleep),
    .clear_watchdog_instr(clr), .sleep_instr(slp_i), .watchdog_reset(wd_rst),
    .watchdog_wake(wd_wake), .expiry_flag(flag));
  wdrw_core_model p (.mclk(mclk), .reset(reset), .watchdog_reset(wd_rst),
    .watchdog_wake(wd_wake), .clear_watchdog_instr(clr), .sleep_instr(slp_i),
    .core_in_sleep(in_sleep));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // reset held 8 cycles; the fuse is settled while reset is high
  task automatic do_reset(input logic f);
    reset = 1'b1;
    fuse = f;
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    chk("flag after reset", flag, 1'b1);
  endtask : do_reset
  // quiet at cycle n-1, then the expected pulse at cycle n for exactly one cycle
  task automatic expect_at(input int n, input logic er, input logic ew);
    repeat (n - 1) @(negedge mclk);
    chk("reset early", wd_rst, 1'b0);
    chk("wake early", wd_wake, 1'b0);
    @(negedge mclk);
    chk("reset", wd_rst, er);
    chk("wake", wd_wake, ew);
    chk("flag", flag, !(er || ew));
    @(negedge mclk);
    chk("pulse width", wd_rst | wd_wake, 1'b0);
    chk("flag holds", flag, !(er || ew));
  endtask : expect_at
  // second clear at cycle k must restart both counts
  task automatic restart_mid(input wdrw_pkg::wdrw_presc_cfg_t c, input int k, input int n);
    do_reset(1'b1);
    cfg = c;
    p.exec(1'b0);
    repeat (k - 1) @(negedge mclk);
    p.exec(1'b0);
    chk("suppressed", wd_rst, 1'b0);
    expect_at(n, 1'b1, 1'b0);
  endtask : restart_mid
  // hang guard, well above the roughly 1240 cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim;
    end
  end
  initial begin
    for (int i = 0; i < 10; i++) begin
      do_reset(1'b1);
      cfg = rows[i].cfg;
      p.exec(rows[i].slp);
      expect_at(int'(rows[i].n), !rows[i].slp, rows[i].slp);
    end
    restart_mid(4'h0, NB, NB);
    restart_mid(4'hA, 6, 16);
    // no clear after release: counts start at the first edge
    do_reset(1'h1);
    cfg = 4'h0;
    repeat (NB - 1) @(negedge mclk);
    // a second reset just before expiry drops that expiry
    do_reset(1'h1);
    expect_at(NB, 1'h1, 1'h0);
    // blown fuse: neither clear, sleep nor waiting brings it back
    do_reset(1'h0);
    p.exec(1'h0);
    expect_at(3 * NB, 1'h0, 1'h0);
    p.exec(1'h1);
    expect_at(3 * NB, 1'h0, 1'h0);
    end_sim;
  end
endmodule : tb_top
